// *** inc/sas_pkg.sv ***
package sas_pkg;
  localparam int ADR_W = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_POWER  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam int CH_LO     = 0;
  localparam int CH_HI     = 2;
  localparam int START_BIT = 3;
  localparam int DONE_BIT  = 4;
  localparam int EXT_BIT   = 5;
  localparam int LSB_LO    = 6;
  localparam int LSB_HI    = 7;
  localparam int PWR_BIT   = 0;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_W     = 2;
  localparam int RES_W     = 10;
  localparam int CONV_CYCLES = 50;
  localparam int STEP_CYCLES = CONV_CYCLES / RES_W;
  localparam logic [5:0] CONV_LAST  = 6'(CONV_CYCLES - 1);
  localparam logic [2:0] PHASE_LAST = 3'(STEP_CYCLES - 1);
  localparam logic [3:0] BIT_TOP    = 4'(RES_W - 1);
  localparam logic [9:0] SAR_INIT   = 10'h200;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  typedef enum {ST_IDLE, ST_CONV} sas_state_e;
endpackage

// *** rtl/sas_sar_adc_sequencer.sv ***
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Ten-bit result by successive approximation
// - Control bits 2:0 select analog channel
// - Every completed conversion lasts exactly fifty cycles
// - No conversion without converter power enable
// - Setting start bit 3 begins conversion
// - External enable clear: pin ignored
// - External enable set: pin edge also starts
// - Pin edge seen, conversion starts next cycle
// - SAR drives DAC, comparator fed back
// - Done flag bit 4 set at end
// - High byte register, two LSBs bits 7:6
// - Starts ignored while a conversion runs
// - Power-down aborts; finished result kept
// - Codes span 000H up to 3FFH
module sas_sar_adc_sequencer
  import sas_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [sas_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      irq,
  input  wire logic                 extStartPin,
  input  wire logic                 powerDown,
  input  wire logic                 compHigh,
  output logic      [2:0]           chanSel,
  output logic      [9:0]           dacCode,
  output logic                      converterOn
);
  import sas_pkg::*;

  sas_state_e       state;
  logic [7:0]       ctrl;
  logic [7:0]       resultHigh;
  logic             pwrEn;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [IRQ_W-1:0] irqEvent;
  logic [5:0]       convCnt;
  logic [2:0]       phase;
  logic [3:0]       bitIdx;
  logic             extMeta;
  logic             extSync;
  logic             extPrev;
  logic             compMeta;
  logic             compSync;
  logic             busy;
  logic             extRise;
  logic             powerOk;
  logic             wbReq;
  logic             wbWr;
  logic             wrCtrl;
  logic             wrPower;
  logic             wrStatus;
  logic             wrMask;
  logic             startReq;
  logic             abortReq;
  logic             lastCyc;
  logic             irqPend;
  logic [9:0]       finalCode;
  logic [7:0]       rdData;

  function automatic logic hit(input logic [ADR_W-1:0] a,
                               input logic [ADR_W-1:0] off);
    return a[ADR_W-1:2] == off[ADR_W-1:2];
  endfunction

  // Pin and comparator are asynchronous to clk
  always_ff @(posedge clk) begin
    if (!rstn) begin
      extMeta  <= 1'b0;
      extSync  <= 1'b0;
      extPrev  <= 1'b0;
      compMeta <= 1'b0;
      compSync <= 1'b0;
    end else if (ce) begin
      extMeta  <= extStartPin;
      extSync  <= extMeta;
      extPrev  <= extSync;
      compMeta <= compHigh;
      compSync <= compMeta;
    end
  end

  // Both levels must be sampled for an edge to count
  assign extRise = extSync & ~extPrev;

  assign busy     = (state == ST_CONV);
  assign powerOk  = pwrEn & ~powerDown;
  assign wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr     = wbReq & wb_we_i & wb_sel_i[0];
  assign wrCtrl   = wbWr & hit(wb_adr_i, OFF_CTRL);
  assign wrPower  = wbWr & hit(wb_adr_i, OFF_POWER);
  assign wrStatus = wbWr & hit(wb_adr_i, OFF_STATUS);
  assign wrMask   = wbWr & hit(wb_adr_i, OFF_MASK);

  // Only an idle, powered converter accepts a start
  assign startReq = ~busy & powerOk &
                    ((wrCtrl & wb_dat_i[START_BIT]) |
                     (extRise & ctrl[EXT_BIT]));
  assign abortReq = busy & ~powerOk;
  // Abort wins over the final cycle, so a cut conversion never stores
  assign lastCyc  = busy & powerOk & (convCnt == CONV_LAST);
  // Last bit is decided in the final cycle itself
  assign finalCode = {dacCode[9:1], compSync};
  assign irqEvent[IRQ_DONE]  = lastCyc;
  assign irqEvent[IRQ_ABORT] = abortReq;
  assign irqPend = |(irqStatus & irqMask);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (startReq) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (abortReq || lastCyc) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Each step takes five cycles, leaving slack for the comparator synchroniser
  always_ff @(posedge clk) begin
    if (!rstn) begin
      convCnt <= 6'h0;
      phase   <= 3'h0;
      bitIdx  <= 4'h0;
      dacCode <= 10'h000;
    end else if (ce) begin
      if (startReq) begin
        convCnt <= 6'h0;
        phase   <= 3'h0;
        bitIdx  <= BIT_TOP;
        dacCode <= SAR_INIT;
      end else if (busy && !abortReq) begin
        convCnt <= convCnt + 6'h1;
        if (phase == PHASE_LAST) begin
          phase <= 3'h0;
          dacCode[bitIdx] <= compSync;
          if (bitIdx != 4'h0) begin
            dacCode[4'(bitIdx - 4'h1)] <= 1'b1;
            bitIdx <= bitIdx - 4'h1;
          end
        end else begin
          phase <= phase + 3'h1;
        end
      end
    end
  end

  // Channel held steady for the whole conversion
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chanSel <= 3'h0;
    end else if (ce && startReq) begin
      chanSel <= wrCtrl ? wb_dat_i[CH_HI:CH_LO] : ctrl[CH_HI:CH_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl <= CTRL_RST;
    end else if (ce) begin
      if (wrCtrl) begin
        ctrl[CH_HI:CH_LO] <= wb_dat_i[CH_HI:CH_LO];
        ctrl[EXT_BIT]     <= wb_dat_i[EXT_BIT];
      end
      if (startReq) begin
        ctrl[START_BIT] <= 1'b1;
      end else if (abortReq || lastCyc) begin
        ctrl[START_BIT] <= 1'b0;
      end
      // Hardware set wins over a software clear
      if (lastCyc) begin
        ctrl[DONE_BIT] <= 1'b1;
      end else if (wrCtrl && !wb_dat_i[DONE_BIT]) begin
        ctrl[DONE_BIT] <= 1'b0;
      end
      if (lastCyc) begin
        ctrl[LSB_HI:LSB_LO] <= finalCode[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      resultHigh <= RESULT_RST;
    end else if (ce && lastCyc) begin
      resultHigh <= finalCode[9:2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pwrEn       <= 1'b0;
      converterOn <= 1'b0;
    end else if (ce) begin
      if (wrPower) begin
        pwrEn <= wb_dat_i[PWR_BIT];
      end
      converterOn <= powerOk;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clk) begin
        if (!rstn) begin
          irqStatus[gi] <= 1'b0;
        end else if (ce) begin
          if (irqEvent[gi]) begin
            irqStatus[gi] <= 1'b1;
          end else if (wrStatus && wb_dat_i[gi]) begin
            irqStatus[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqMask <= MASK_RST[IRQ_W-1:0];
      irq     <= 1'b0;
    end else if (ce) begin
      if (wrMask) begin
        irqMask <= wb_dat_i[IRQ_W-1:0];
      end
      irq <= irqPend;
    end
  end

  always_comb begin
    rdData = 8'h00;
    if (hit(wb_adr_i, OFF_CTRL)) begin
      rdData = ctrl;
    end else if (hit(wb_adr_i, OFF_RESULT)) begin
      rdData = resultHigh;
    end else if (hit(wb_adr_i, OFF_POWER)) begin
      rdData[PWR_BIT] = pwrEn;
    end else if (hit(wb_adr_i, OFF_STATUS)) begin
      rdData[IRQ_W-1:0] = irqStatus;
    end else if (hit(wb_adr_i, OFF_MASK)) begin
      rdData[IRQ_W-1:0] = irqMask;
    end
  end

  // Single wait state; unmapped offsets still answer, reading zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rdData};
      end
    end
  end

  property p_len;
    @(posedge clk) disable iff (!rstn || !ce)
      $fell(busy) && !$past(abortReq) |->
        $past(convCnt) == CONV_LAST && irqStatus[IRQ_DONE];
  endproperty
  a_len: assert property (p_len)
    else $error("conversion did not last fifty cycles");

  property p_first;
    @(posedge clk) disable iff (!rstn || !ce)
      $rose(busy) |-> convCnt == 6'h0 && dacCode == SAR_INIT && ctrl[START_BIT];
  endproperty
  a_first: assert property (p_first)
    else $error("conversion began in a wrong state");

  property p_power;
    @(posedge clk) disable iff (!rstn || !ce)
      !pwrEn |=> !busy;
  endproperty
  a_power: assert property (p_power)
    else $error("conversion running without power enable");

  property p_ext;
    @(posedge clk) disable iff (!rstn || !ce)
      extRise && ctrl[EXT_BIT] && !busy && powerOk |=> busy ##0 ctrl[START_BIT];
  endproperty
  a_ext: assert property (p_ext)
    else $error("external edge failed to start conversion");

  property p_noext;
    @(posedge clk) disable iff (!rstn || !ce)
      extRise && !ctrl[EXT_BIT] && !wrCtrl && !busy |=> !busy;
  endproperty
  a_noext: assert property (p_noext)
    else $error("pin started conversion while disabled");

  property p_hold;
    @(posedge clk) disable iff (!rstn || !ce)
      busy && $past(busy) && $past(ce) |->
        $stable(chanSel) && convCnt == $past(convCnt) + 6'h1;
  endproperty
  a_hold: assert property (p_hold)
    else $error("running conversion was disturbed");

  property p_abort;
    @(posedge clk) disable iff (!rstn || !ce)
      busy && powerDown |=> !busy && !ctrl[START_BIT] && $stable(resultHigh);
  endproperty
  a_abort: assert property (p_abort)
    else $error("power-down did not abort cleanly");

  property p_result;
    @(posedge clk) disable iff (!rstn || !ce)
      lastCyc |=> ctrl[DONE_BIT] && {resultHigh, ctrl[LSB_HI:LSB_LO]} == dacCode;
  endproperty
  a_result: assert property (p_result)
    else $error("result not stored at end of conversion");

  property p_sticky;
    @(posedge clk) disable iff (!rstn || !ce)
      ctrl[DONE_BIT] && !wrCtrl |=> ctrl[DONE_BIT];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("done flag cleared without a write");

  property p_clrstart;
    @(posedge clk) disable iff (!rstn || !ce)
      $fell(busy) |-> !ctrl[START_BIT];
  endproperty
  a_clrstart: assert property (p_clrstart)
    else $error("start bit left set after conversion");

  property p_irq;
    @(posedge clk) disable iff (!rstn || !ce)
      $past(ce) |-> irq == $past(irqPend);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output mismatches status and mask");

  property p_chan;
    @(posedge clk) disable iff (!rstn || !ce)
      $rose(busy) |-> chanSel == ctrl[CH_HI:CH_LO];
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel select differs from control field at start");

  property p_ack;
    @(posedge clk) disable iff (!rstn || !ce)
      wbReq |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus acknowledge not a single cycle after request");
endmodule

// *** dv/sas_analog_model.sv ***
`timescale 1ns/1ns
module sas_analog_model
  import sas_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [2:0] chanSel,
  input  wire logic [9:0] dacCode,
  input  wire logic       converterOn,
  output logic            compHigh
);
  logic [9:0] level [8];
  logic       wander = 1'b0;
  initial begin
    foreach (level[i]) level[i] = 10'h000;
  end
  always @(posedge clk) wander <= ~wander;
  // Keep the trial bit while the input is at or above the DAC
  // Unpowered comparator output is junk, so it must not look settled
  assign compHigh = converterOn ? (level[chanSel] >= dacCode) : wander;
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ns
module tb;
  import sas_pkg::*;
  logic        clk, rstn, ce, cyc, stb, we, pin, pdn, comp, irq, ack, cvOn;
  logic [7:0]  adr;
  logic [31:0] wdat, dout, rdat;
  logic [2:0]  chan;
  logic [9:0]  dac;
  int          numErrors, totalChecks;
  localparam logic [9:0] CODES [8] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA,
                                      10'h001, 10'h200, 10'h1FF, 10'h3FE};
  localparam logic [7:0] OFFS [6] = '{OFF_CTRL, OFF_RESULT, OFF_POWER, OFF_STATUS,
                                     OFF_MASK, 8'h14};
  sas_sar_adc_sequencer sas_sar_adc_sequencer_i (
    .clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .irq(irq), .extStartPin(pin), .powerDown(pdn), .compHigh(comp), .chanSel(chan),
    .dacCode(dac), .converterOn(cvOn));
  sas_analog_model sas_analog_model_i (.clk(clk), .chanSel(chan), .dacCode(dac),
    .converterOn(cvOn), .compHigh(comp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Entered right after a rising edge; returns right after one
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Looks n edges on: irq still low, then high one edge later
  task automatic done_at(input int n);
    repeat (n) @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0000);
    @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0001);
    @(posedge clk);
  endtask
  task automatic pulse;
    pin <= 1'b0;
    repeat (2) @(posedge clk);
    pin <= 1'b1;
    repeat (2) @(posedge clk);
    pin <= 1'b0;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    numErrors++;
    $display("FAIL %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    {cyc, stb, we, pin, pdn, rstn} = '0;
    ce = 1'b1;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    numErrors = 0;
    totalChecks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b1, OFF_RESULT, 8'hFF);
    bus(1'b1, 8'h14, 8'hFF);
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, OFFS[k], 8'h00);
      chk(rdat, 32'h0000_0000);
    end
    $display("test registers done");
    bus(1'b1, OFF_POWER, 8'h01);
    bus(1'b1, OFF_MASK, 8'h01);
    for (int i = 0; i < 8; i++) begin
      sas_analog_model_i.level[i] = CODES[i];
      bus(1'b1, OFF_STATUS, 8'h01);
      bus(1'b1, OFF_CTRL, 8'h18 | 8'(i));
      bus(1'b0, OFF_CTRL, 8'h00);
      chk(rdat & 32'h3F, 32'({i > 0, 1'b1, i[2:0]}));
      chk(32'(chan), 32'(i));
      done_at(45);
      bus(1'b0, OFF_RESULT, 8'h00);
      chk(rdat, 32'(CODES[i][9:2]));
      bus(1'b0, OFF_CTRL, 8'h00);
      chk(rdat, 32'({CODES[i][1:0], 3'b010, i[2:0]}));
    end
    $display("test channels done");
    sas_analog_model_i.level[3] = 10'h0F0;
    sas_analog_model_i.level[4] = 10'h3C3;
    bus(1'b1, OFF_STATUS, 8'h01);
    bus(1'b1, OFF_CTRL, 8'h0B);
    bus(1'b1, OFF_CTRL, 8'h0C);
    done_at(45);
    bus(1'b0, OFF_RESULT, 8'h00);
    chk(rdat, 32'h0000_003C);
    bus(1'b1, OFF_CTRL, 8'h00);
    bus(1'b0, OFF_CTRL, 8'h00);
    chk(rdat, 32'h0000_0000);
    $display("test restart ignored done");
    bus(1'b1, OFF_STATUS, 8'h03);
    bus(1'b1, OFF_POWER, 8'h00);
    bus(1'b1, OFF_CTRL, 8'h08);
    repeat (55) @(posedge clk);
    bus(1'b0, OFF_STATUS, 8'h00);
    chk(rdat, 32'h0000_0000);
    bus(1'b1, OFF_POWER, 8'h01);
    bus(1'b1, OFF_CTRL, 8'h09);
    repeat (10) @(posedge clk);
    pdn <= 1'b1;
    @(posedge clk);
    pdn <= 1'b0;
    repeat (50) @(posedge clk);
    bus(1'b0, OFF_STATUS, 8'h00);
    chk(rdat, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000);
    bus(1'b0, OFF_CTRL, 8'h00);
    chk(rdat, 32'h0000_0001);
    bus(1'b0, OFF_RESULT, 8'h00);
    chk(rdat, 32'h0000_003C);
    bus(1'b1, OFF_MASK, 8'h03);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, OFF_STATUS, 8'h03);
    chk(32'(irq), 32'h0000_0000);
    $display("test abort done");
    sas_analog_model_i.level[2] = 10'h1A5;
    bus(1'b1, OFF_CTRL, 8'h02);
    pulse();
    repeat (4) @(posedge clk);
    bus(1'b0, OFF_CTRL, 8'h00);
    chk(rdat, 32'h0000_0002);
    bus(1'b1, OFF_CTRL, 8'h22);
    pulse();
    repeat (2) @(posedge clk);
    bus(1'b0, OFF_CTRL, 8'h00);
    chk(rdat, 32'h0000_002A);
    repeat (50) @(posedge clk);
    bus(1'b0, OFF_RESULT, 8'h00);
    chk(rdat, 32'h0000_0069);
    bus(1'b0, OFF_CTRL, 8'h00);
    chk(rdat, 32'h0000_0072);
    $display("test external start done");
    bus(1'b1, OFF_STATUS, 8'h03);
    bus(1'b1, OFF_CTRL, 8'h1D);
    // Twenty frozen edges push completion back by exactly twenty
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    done_at(48);
    bus(1'b0, OFF_RESULT, 8'h00);
    chk(rdat, 32'h0000_0080);
    $display("test clock enable done");
    close_out();
  end
endmodule
